// [include/cids_map.svh]
// Opcode, field, reset and flag constants for the instruction decode subset
`ifndef CIDS_MAP_SVH
`define CIDS_MAP_SVH
// ==========================================================
// Reset values
`define CIDS_PC_RST     16'h0000
`define CIDS_SP_RST     16'h00FF
`define CIDS_CCR_RST    8'h68
// ==========================================================
// Condition flag bit positions
`define CIDS_F_V        7
`define CIDS_F_H        4
`define CIDS_F_I        3
`define CIDS_F_N        2
`define CIDS_F_Z        1
`define CIDS_F_C        0
// ==========================================================
// Opcode fields
`define CIDS_OP_PREFIX  8'h9E
`define CIDS_OP_AIS     8'hA7
`define CIDS_OP_AIX     8'hAF
`define CIDS_HI_IMM     4'hA
`define CIDS_HI_DIR     4'hB
`define CIDS_HI_EXT     4'hC
`define CIDS_HI_IX2     4'hD
`define CIDS_HI_IX1     4'hE
`define CIDS_HI_IX      4'hF
`define CIDS_HI_SDIR    4'h3
`define CIDS_HI_SHA     4'h4
`define CIDS_HI_SHX     4'h5
`define CIDS_HI_SIX1    4'h6
`define CIDS_HI_SIX     4'h7
`define CIDS_HI_BRANCH_ON_BIT_CLEAR   4'h0
`define CIDS_HI_CLEAR_MEMORY_BIT    4'h1
`define CIDS_LO_ADC     4'h9
`define CIDS_LO_ADD     4'hB
`define CIDS_LO_AND     4'h4
`define CIDS_LO_BIT     4'h5
`define CIDS_LO_ASL     4'h8
`define CIDS_LO_ASR     4'h7
// ==========================================================
// Relative branch opcodes
`define CIDS_OP_BHI     8'h22
`define CIDS_OP_BLS     8'h23
`define CIDS_OP_BCC     8'h24
`define CIDS_OP_BCS     8'h25
`define CIDS_OP_BRANCH_HALFCARRY_CLEAR    8'h28
`define CIDS_OP_BRANCH_HALFCARRY_SET    8'h29
`define CIDS_OP_BMC     8'h2C
`define CIDS_OP_BMS     8'h2D
`define CIDS_OP_BIL     8'h2E
`define CIDS_OP_BIH     8'h2F
`define CIDS_OP_BGE     8'h90
`define CIDS_OP_BLT     8'h91
`define CIDS_OP_BGT     8'h92
`define CIDS_OP_BLE     8'h93
`endif

// [include/cids_pkg.sv]
// Types for the instruction decode subset
package cids_pkg;
  // ==========================================================
  // Sequencer states, operand modes, instruction classes
  typedef enum logic [2:0] {ST_FETCH, ST_PRE, ST_B1, ST_B2, ST_RD, ST_WR, ST_REL, ST_PAD} cids_state_t;
  typedef enum logic [3:0] {M_INH, M_IMM, M_DIR, M_EXT, M_IX2, M_IX1, M_IX, M_SP1, M_SP2} cids_mode_t;
  typedef enum logic [3:0] {C_ADC, C_ADD, C_AND, C_BIT, C_ASL, C_ASR, C_AIS, C_AIX, C_REL, C_CLEAR_MEMORY_BIT, C_BRANCH_ON_BIT_CLEAR,
                            C_ILL} cids_cls_t;
  typedef struct packed {
    cids_cls_t  cls;
    cids_mode_t mode;
  } cids_dec_t;
endpackage

// [src/cids_core.sv]
// Sequencer and execute logic for the instruction decode subset
//
// Function
// - ADC adds A, operand, carry; five flags
// - ADD adds A and operand; five flags
// - AND stores A&M, clears V, sets N,Z
// - BIT tests A&M without storing result
// - Stack pointer plus sign-extended immediate
// - Index pair plus sign-extended immediate
// - Shift left, bit7 to carry, zero in
// - Shift right keeps bit7, bit0 to carry
// - Branch on carry clear or set
// - Signed compare branches from N, V, Z
// - Unsigned higher / lower-same from C|Z
// - Branch on half-carry clear or set
// - Branch on interrupt pin level
// - Branch on interrupt mask flag
// - Clear direct-page memory bit, four cycles
// - Test memory bit into carry, branch
`timescale 1ns/1ns
`include "cids_map.svh"
module cids_core
  import cids_pkg::*;
(
  input  wire logic        clk_i,        // Core clock
  input  wire logic        rst_i,        // Async reset, high
  input  wire logic [7:0]  mem_rdata_i,  // Byte at mem_addr_o
  input  wire logic        irq_n_i,      // Interrupt pin level
  output logic      [15:0] mem_addr_o,   // Bus address
  output logic             mem_wr_o,     // Write strobe
  output logic      [7:0]  mem_wdata_o,  // Write data
  output logic      [7:0]  acc_o,        // Accumulator
  output logic      [15:0] idx_o,        // Index pair H:X
  output logic      [15:0] sp_o,         // Stack pointer
  output logic      [15:0] pc_o,         // Program counter
  output logic      [7:0]  flags_o,      // Condition flags
  output logic             instr_done_o, // Instruction retired
  output logic             illegal_o     // Opcode not handled
);
  // ==========================================================
  // Decode helpers
  function automatic cids_dec_t decode(input logic pre, input logic [7:0] op);
    cids_dec_t r;
    r.cls  = C_ILL;
    r.mode = M_INH;
    // Only the four operand-class low nibbles qualify, so A7 and AF fall through to the immediate adds
    if (op[7:4] >= `CIDS_HI_IMM && (!pre || op[7:4] == `CIDS_HI_IX2 || op[7:4] == `CIDS_HI_IX1) &&
        (op[3:0] == `CIDS_LO_ADC || op[3:0] == `CIDS_LO_ADD || op[3:0] == `CIDS_LO_AND ||
         op[3:0] == `CIDS_LO_BIT))
    begin
      case (op[3:0])
        `CIDS_LO_ADC: r.cls = C_ADC;
        `CIDS_LO_ADD: r.cls = C_ADD;
        `CIDS_LO_AND: r.cls = C_AND;
        `CIDS_LO_BIT: r.cls = C_BIT;
        default:      r.cls = C_ILL;
      endcase
      case (op[7:4])
        `CIDS_HI_IMM: r.mode = M_IMM;
        `CIDS_HI_DIR: r.mode = M_DIR;
        `CIDS_HI_EXT: r.mode = M_EXT;
        `CIDS_HI_IX2: r.mode = pre ? M_SP2 : M_IX2;
        `CIDS_HI_IX1: r.mode = pre ? M_SP1 : M_IX1;
        default:      r.mode = M_IX;
      endcase
    end
    else if ((op[3:0] == `CIDS_LO_ASL || op[3:0] == `CIDS_LO_ASR) &&
             (pre ? op[7:4] == `CIDS_HI_SIX1 : (op[7:4] >= `CIDS_HI_SDIR && op[7:4] <= `CIDS_HI_SIX)))
    begin
      r.cls = (op[3:0] == `CIDS_LO_ASL) ? C_ASL : C_ASR;
      case (op[7:4])
        `CIDS_HI_SDIR: r.mode = M_DIR;
        `CIDS_HI_SIX1: r.mode = pre ? M_SP1 : M_IX1;
        `CIDS_HI_SIX:  r.mode = M_IX;
        default:       r.mode = M_INH;
      endcase
    end
    else if (!pre)
    begin
      case (op)
        `CIDS_OP_AIS: r = '{C_AIS, M_IMM};
        `CIDS_OP_AIX: r = '{C_AIX, M_IMM};
        `CIDS_OP_BHI, `CIDS_OP_BLS, `CIDS_OP_BCC, `CIDS_OP_BCS, `CIDS_OP_BRANCH_HALFCARRY_CLEAR, `CIDS_OP_BRANCH_HALFCARRY_SET,
        `CIDS_OP_BMC, `CIDS_OP_BMS, `CIDS_OP_BIL, `CIDS_OP_BIH, `CIDS_OP_BGE, `CIDS_OP_BLT,
        `CIDS_OP_BGT, `CIDS_OP_BLE: r.cls = C_REL;
        default:
        begin
          if (op[0] && op[7:4] == `CIDS_HI_CLEAR_MEMORY_BIT) r = '{C_CLEAR_MEMORY_BIT, M_DIR};
          if (op[0] && op[7:4] == `CIDS_HI_BRANCH_ON_BIT_CLEAR) r = '{C_BRANCH_ON_BIT_CLEAR, M_DIR};
        end
      endcase
    end
    return r;
  endfunction

  // Effective address; one-byte modes pass zero as hi
  function automatic logic [15:0] ea(input cids_mode_t m, input logic [7:0] hi, input logic [7:0] lo,
                                     input logic [15:0] hx, input logic [15:0] sp);
    case (m)
      M_IX2, M_IX1, M_IX: return hx + {hi, lo};
      M_SP1, M_SP2:       return sp + {hi, lo};
      default:            return {hi, lo};
    endcase
  endfunction

  function automatic logic [15:0] sext(input logic [7:0] b);
    return {{8{b[7]}}, b};
  endfunction

  // ==========================================================
  // State
  cids_state_t st_q, st_d;
  cids_cls_t   cls_q, cls_d, cur_cls;
  cids_mode_t  mode_q, mode_d;
  cids_dec_t   dc;
  logic [15:0] pc_q, pc_d, addr_q, addr_d, sp_q, sp_d, pc1, hx;
  logic [7:0]  a_q, a_d, x_q, x_d, h_q, h_d, ccr_q, ccr_d, op_q, op_d, b1_q, b1_d;
  logic [7:0]  wdata_q, wdata_d, sh_in, alu_r, alu_ccr;
  logic [8:0]  sum9;
  logic        wr_q, wr_d, done_q, done_d, ill_q, ill_d;
  logic        pin_m_q, pin_q, alu_go, take, rd_bit;

  assign hx     = {h_q, x_q};
  assign pc1    = pc_q + 16'h0001;
  assign dc     = decode(st_q == ST_PRE, mem_rdata_i);
  assign rd_bit = mem_rdata_i[op_q[3:1]];
  // During opcode cycles the class is not yet registered
  assign cur_cls = (st_q == ST_FETCH || st_q == ST_PRE) ? dc.cls : cls_q;
  assign alu_go  = (st_q == ST_RD || (st_q == ST_B1 && mode_q == M_IMM)) && cls_q <= C_BIT;

  // ==========================================================
  // Branch condition, read straight from flags and the two-flop synchronised pin
  always_comb
  begin
    take = 1'b0;
    if (cls_q == C_BRANCH_ON_BIT_CLEAR)
      take = !ccr_q[`CIDS_F_C];
    else
      case (op_q)
        `CIDS_OP_BCC:  take = !ccr_q[`CIDS_F_C];
        `CIDS_OP_BCS:  take = ccr_q[`CIDS_F_C];
        `CIDS_OP_BGE:  take = !(ccr_q[`CIDS_F_N] ^ ccr_q[`CIDS_F_V]);
        `CIDS_OP_BLT:  take = ccr_q[`CIDS_F_N] ^ ccr_q[`CIDS_F_V];
        `CIDS_OP_BGT:  take = !(ccr_q[`CIDS_F_Z] | (ccr_q[`CIDS_F_N] ^ ccr_q[`CIDS_F_V]));
        `CIDS_OP_BLE:  take = ccr_q[`CIDS_F_Z] | (ccr_q[`CIDS_F_N] ^ ccr_q[`CIDS_F_V]);
        `CIDS_OP_BHI:  take = !(ccr_q[`CIDS_F_C] | ccr_q[`CIDS_F_Z]);
        `CIDS_OP_BLS:  take = ccr_q[`CIDS_F_C] | ccr_q[`CIDS_F_Z];
        `CIDS_OP_BRANCH_HALFCARRY_CLEAR: take = !ccr_q[`CIDS_F_H];
        `CIDS_OP_BRANCH_HALFCARRY_SET: take = ccr_q[`CIDS_F_H];
        `CIDS_OP_BIH:  take = pin_q;
        `CIDS_OP_BIL:  take = !pin_q;
        `CIDS_OP_BMC:  take = !ccr_q[`CIDS_F_I];
        `CIDS_OP_BMS:  take = ccr_q[`CIDS_F_I];
        default:       take = 1'b0;
      endcase
  end

  // ==========================================================
  // Arithmetic, logic and shift unit
  always_comb
  begin
    sh_in   = (st_q == ST_RD) ? mem_rdata_i : ((mem_rdata_i[7:4] == `CIDS_HI_SHX) ? x_q : a_q);
    sum9    = {1'b0, a_q} + {1'b0, mem_rdata_i} + {8'h00, (cur_cls == C_ADC) & ccr_q[`CIDS_F_C]};
    alu_r   = a_q & mem_rdata_i;
    alu_ccr = ccr_q;
    case (cur_cls)
      C_ADC, C_ADD:
      begin
        alu_r = sum9[7:0];
        alu_ccr[`CIDS_F_V] = (a_q[7] & mem_rdata_i[7] & !alu_r[7]) | (!a_q[7] & !mem_rdata_i[7] & alu_r[7]);
        alu_ccr[`CIDS_F_H] = (a_q[3] & mem_rdata_i[3]) | (mem_rdata_i[3] & !alu_r[3]) | (!alu_r[3] & a_q[3]);
        alu_ccr[`CIDS_F_C] = sum9[8];
      end
      C_ASL:
      begin
        alu_r = {sh_in[6:0], 1'b0};
        alu_ccr[`CIDS_F_C] = sh_in[7];
      end
      C_ASR:
      begin
        alu_r = {sh_in[7], sh_in[7:1]};
        alu_ccr[`CIDS_F_C] = sh_in[0];
      end
      default: alu_ccr[`CIDS_F_V] = 1'b0;
    endcase
    alu_ccr[`CIDS_F_N] = alu_r[7];
    alu_ccr[`CIDS_F_Z] = (alu_r == 8'h00);
    // Shifts report V as N xor C after the move
    if (cur_cls == C_ASL || cur_cls == C_ASR)
      alu_ccr[`CIDS_F_V] = alu_r[7] ^ alu_ccr[`CIDS_F_C];
  end

  // ==========================================================
  // Instruction sequencer: one state per bus cycle, so each
  // instruction takes exactly its documented cycle count
  always_comb
  begin
    st_d    = st_q;
    pc_d    = pc_q;
    addr_d  = addr_q;
    a_d     = a_q;
    x_d     = x_q;
    h_d     = h_q;
    sp_d    = sp_q;
    ccr_d   = ccr_q;
    op_d    = op_q;
    cls_d   = cls_q;
    mode_d  = mode_q;
    b1_d    = b1_q;
    wdata_d = wdata_q;
    wr_d    = 1'b0;
    done_d  = 1'b0;
    ill_d   = 1'b0;
    unique case (st_q)
      ST_FETCH, ST_PRE:
      begin
        pc_d   = pc1;
        addr_d = pc1;
        if (st_q == ST_FETCH && mem_rdata_i == `CIDS_OP_PREFIX)
          st_d = ST_PRE;
        else
        begin
          op_d   = mem_rdata_i;
          cls_d  = dc.cls;
          mode_d = dc.mode;
          if (dc.cls == C_ILL)
          begin
            // Unhandled opcodes retire as one-cycle no-ops
            ill_d  = 1'b1;
            done_d = 1'b1;
          end
          else if (dc.cls == C_REL)
            st_d = ST_REL;
          else if (dc.mode == M_INH)
          begin
            if (mem_rdata_i[7:4] == `CIDS_HI_SHX)
              x_d = alu_r;
            else
              a_d = alu_r;
            ccr_d  = alu_ccr;
            done_d = 1'b1;
            st_d   = ST_FETCH;
          end
          else if (dc.mode == M_IX)
          begin
            addr_d = hx;
            st_d   = ST_RD;
          end
          else
            st_d = ST_B1;
        end
      end
      ST_B1:
      begin
        pc_d   = pc1;
        addr_d = pc1;
        b1_d   = mem_rdata_i;
        st_d   = ST_FETCH;
        if (mode_q == M_EXT || mode_q == M_IX2 || mode_q == M_SP2)
          st_d = ST_B2;
        else if (cls_q == C_AIS)
        begin
          sp_d   = sp_q + sext(mem_rdata_i);
          done_d = 1'b1;
        end
        else if (cls_q == C_AIX)
        begin
          {h_d, x_d} = hx + sext(mem_rdata_i);
          done_d     = 1'b1;
        end
        else if (alu_go)
        begin
          a_d    = (cls_q == C_BIT) ? a_q : alu_r;
          ccr_d  = alu_ccr;
          done_d = 1'b1;
        end
        else
        begin
          addr_d = ea(mode_q, 8'h00, mem_rdata_i, hx, sp_q);
          st_d   = ST_RD;
        end
      end
      ST_B2:
      begin
        pc_d   = pc1;
        addr_d = ea(mode_q, b1_q, mem_rdata_i, hx, sp_q);
        st_d   = ST_RD;
      end
      ST_RD:
      begin
        addr_d = pc_q;
        st_d   = ST_FETCH;
        case (cls_q)
          C_ASL, C_ASR:
          begin
            wr_d    = 1'b1;
            wdata_d = alu_r;
            ccr_d   = alu_ccr;
            addr_d  = addr_q;
            st_d    = ST_WR;
          end
          C_CLEAR_MEMORY_BIT:
          begin
            wr_d    = 1'b1;
            wdata_d = mem_rdata_i & ~(8'h01 << op_q[3:1]);
            addr_d  = addr_q;
            st_d    = ST_WR;
          end
          C_BRANCH_ON_BIT_CLEAR:
          begin
            ccr_d[`CIDS_F_C] = rd_bit;
            st_d             = ST_REL;
          end
          default:
          begin
            a_d    = (cls_q == C_BIT) ? a_q : alu_r;
            ccr_d  = alu_ccr;
            done_d = 1'b1;
          end
        endcase
      end
      ST_WR:
      begin
        addr_d = pc_q;
        done_d = 1'b1;
        st_d   = ST_FETCH;
      end
      ST_REL:
      begin
        // Offset is relative to the byte after the offset
        pc_d   = take ? pc1 + sext(mem_rdata_i) : pc1;
        addr_d = pc_d;
        st_d   = ST_PAD;
      end
      ST_PAD:
      begin
        done_d = 1'b1;
        st_d   = ST_FETCH;
      end
    endcase
  end

  // Register stage; pin level passes two flops first
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q    <= ST_FETCH;
      pc_q    <= `CIDS_PC_RST;
      addr_q  <= `CIDS_PC_RST;
      sp_q    <= `CIDS_SP_RST;
      ccr_q   <= `CIDS_CCR_RST;
      a_q     <= 8'h00;
      x_q     <= 8'h00;
      h_q     <= 8'h00;
      op_q    <= 8'h00;
      b1_q    <= 8'h00;
      cls_q   <= C_ILL;
      mode_q  <= M_INH;
      wdata_q <= 8'h00;
      wr_q    <= 1'b0;
      done_q  <= 1'b0;
      ill_q   <= 1'b0;
      pin_m_q <= 1'b1;
      pin_q   <= 1'b1;
    end
    else
    begin
      st_q    <= st_d;
      pc_q    <= pc_d;
      addr_q  <= addr_d;
      sp_q    <= sp_d;
      ccr_q   <= ccr_d;
      a_q     <= a_d;
      x_q     <= x_d;
      h_q     <= h_d;
      op_q    <= op_d;
      b1_q    <= b1_d;
      cls_q   <= cls_d;
      mode_q  <= mode_d;
      wdata_q <= wdata_d;
      wr_q    <= wr_d;
      done_q  <= done_d;
      ill_q   <= ill_d;
      pin_m_q <= irq_n_i;
      pin_q   <= pin_m_q;
    end
  end

  assign mem_addr_o   = addr_q;
  assign mem_wr_o     = wr_q;
  assign mem_wdata_o  = wdata_q;
  assign acc_o        = a_q;
  assign idx_o        = hx;
  assign sp_o         = sp_q;
  assign pc_o         = pc_q;
  assign flags_o      = ccr_q;
  assign instr_done_o = done_q;
  assign illegal_o    = ill_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_rel_start;
    st_q == ST_FETCH && mem_rdata_i != `CIDS_OP_PREFIX && dc.cls == C_REL;
  endsequence
  sequence s_rel_body;
    st_q == ST_REL ##1 st_q == ST_PAD ##1 (st_q == ST_FETCH && instr_done_o);
  endsequence

  property p_rel_len;
    s_rel_start |=> s_rel_body ##0 (ccr_q == $past(ccr_q, 3));
  endproperty
  a_rel_len: assert property (p_rel_len) else $error("relative branch length or flags wrong");

  property p_rel_tgt;
    st_q == ST_REL && take |=> pc_q == $past(pc_q) + 16'h0001 + {{8{$past(mem_rdata_i[7])}}, $past(mem_rdata_i)};
  endproperty
  a_rel_tgt: assert property (p_rel_tgt) else $error("taken branch target wrong");

  property p_ge_not;
    st_q == ST_REL && op_q == `CIDS_OP_BGE && (ccr_q[`CIDS_F_N] ^ ccr_q[`CIDS_F_V]) |=> pc_q == $past(pc1);
  endproperty
  a_ge_not: assert property (p_ge_not) else $error("signed branch taken wrongly");

  property p_pin_low;
    st_q == ST_REL && op_q == `CIDS_OP_BIH && !pin_q |=> pc_q == $past(pc1);
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin branch taken on low pin");

  property p_ais;
    st_q == ST_B1 && cls_q == C_AIS |=> sp_q == $past(sp_q) + {{8{$past(mem_rdata_i[7])}}, $past(mem_rdata_i)}
                                       && ccr_q == $past(ccr_q) && instr_done_o;
  endproperty
  a_ais: assert property (p_ais) else $error("stack pointer add wrong");

  property p_aix;
    st_q == ST_B1 && cls_q == C_AIX |=> idx_o == $past(idx_o) + {{8{$past(mem_rdata_i[7])}}, $past(mem_rdata_i)}
                                       && ccr_q == $past(ccr_q);
  endproperty
  a_aix: assert property (p_aix) else $error("index pair add wrong");

  property p_adc;
    alu_go && cls_q == C_ADC |=> a_q == $past(a_q) + $past(mem_rdata_i) + {7'h00, $past(ccr_q[`CIDS_F_C])};
  endproperty
  a_adc: assert property (p_adc) else $error("add with carry result wrong");

  property p_and;
    alu_go && cls_q == C_AND |=> !ccr_q[`CIDS_F_V] && ccr_q[`CIDS_F_C] == $past(ccr_q[`CIDS_F_C])
                                 && a_q == ($past(a_q) & $past(mem_rdata_i));
  endproperty
  a_and: assert property (p_and) else $error("logical and wrong");

  property p_bit;
    alu_go && cls_q == C_BIT |=> a_q == $past(a_q) && ccr_q[`CIDS_F_Z] == (($past(a_q) & $past(mem_rdata_i)) == 8'h00);
  endproperty
  a_bit: assert property (p_bit) else $error("bit test wrong");

  property p_asla;
    st_q == ST_FETCH && dc.cls == C_ASL && mem_rdata_i[7:4] == `CIDS_HI_SHA
      |=> a_q == {$past(a_q[6:0]), 1'b0} && ccr_q[`CIDS_F_C] == $past(a_q[7]) && instr_done_o;
  endproperty
  a_asla: assert property (p_asla) else $error("accumulator shift left wrong");

  property p_clear_memory_bit;
    st_q == ST_RD && cls_q == C_CLEAR_MEMORY_BIT |=> mem_wr_o && !mem_wdata_o[op_q[3:1]] ##1 instr_done_o && !mem_wr_o;
  endproperty
  a_clear_memory_bit: assert property (p_clear_memory_bit) else $error("bit clear write wrong");

  property p_branch_on_bit_clear;
    st_q == ST_RD && cls_q == C_BRANCH_ON_BIT_CLEAR |=> ccr_q[`CIDS_F_C] == $past(rd_bit) && st_q == ST_REL ##2 instr_done_o;
  endproperty
  a_branch_on_bit_clear: assert property (p_branch_on_bit_clear) else $error("bit branch carry or length wrong");
endmodule // cids_core

// [verif/cids_core_bench.sv]
// Self-checking bench for the instruction decode subset
`timescale 1ns/1ns
module cids_core_bench;
  import cids_pkg::*;
  // ==========================================================
  // Signals
  logic        clk_i;
  logic        rst_i;
  logic        irq_n;
  logic [7:0]  rdata;
  logic [15:0] addr;
  logic        wr;
  logic [7:0]  wdata;
  logic [7:0]  acc;
  logic [15:0] idx;
  logic [15:0] sp;
  logic [15:0] pc;
  logic [7:0]  flags;
  logic        done;
  logic        illegal;
  int          n_fail;
  int          n_compared;
  int          n_cycles;
  // Prefix adds a, b, then branch op; irq level and outcome in low nibbles
  localparam logic [31:0] BR_TAB [24] = '{
    32'h8080_2210, 32'h0100_2211, 32'h8080_2311, 32'h0100_2310, 32'h8080_2410, 32'h0100_2411,
    32'h8080_2511, 32'h0100_2510, 32'h0808_2810, 32'h0100_2811, 32'h0808_2911, 32'h0100_2C10,
    32'h0100_2D11, 32'h0100_2E10, 32'h0100_2E01, 32'h0100_2F11, 32'h0100_2F00, 32'h4040_9011,
    32'h8080_9010, 32'h8080_9111, 32'h8080_9210, 32'h0100_9211, 32'h8080_9311, 32'h4040_9310};
  // ==========================================================
  // Design and memory
  cids_core uut (.clk_i(clk_i), .rst_i(rst_i), .mem_rdata_i(rdata), .irq_n_i(irq_n), .mem_addr_o(addr),
    .mem_wr_o(wr), .mem_wdata_o(wdata), .acc_o(acc), .idx_o(idx), .sp_o(sp), .pc_o(pc), .flags_o(flags),
    .instr_done_o(done), .illegal_o(illegal));
  cids_mem_model mem (.clk_i(clk_i), .addr_i(addr), .wr_i(wr), .wdata_i(wdata), .rdata_o(rdata));
  // Free-running 100 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Hang guard, well above the whole run
  always @(posedge clk_i)
  begin
    n_cycles++;
    if (n_cycles == 3000)
    begin
      n_fail++;
      complete_run();
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Flags of an 8-bit add with carry clear, mask set
  function automatic logic [7:0] add_flags(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] hs;
    s = {1'b0, a} + {1'b0, b};
    hs = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    return {(a[7] == b[7]) && (s[7] != a[7]), 2'b11, hs[4], 1'b1, s[7], s[7:0] == 8'h00, s[8]};
  endfunction
  // Hold reset, blank memory so stray fetches are harmless no-ops
  task automatic restart(input logic irq);
    rst_i = 1'b1;
    irq_n = irq;
    for (int i = 0; i < 65536; i++) mem.mem_q[i] = 8'h9D;
    @(posedge clk_i);
    #1;
    check(sp, 16'h00FF);
    check(16'(flags), 16'h0068);
  endtask
  task automatic load(input logic [15:0] a, input logic [7:0] b[$]);
    foreach (b[i]) mem.mem_q[16'(a + i)] = b[i];
  endtask
  // Counts cycles up to the next retire pulse
  task automatic step(input int cyc);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    while (done !== 1'b1 && n < 20);
    check(16'(n), 16'(cyc));
    check(16'(illegal), 16'h0000);
  endtask
  task automatic exec(input int cyc, input logic [7:0] a, input logic [7:0] f);
    step(cyc);
    check(16'(acc), 16'(a));
    check(16'(flags), 16'(f));
  endtask
  // ==========================================================
  // Scenarios
  task automatic test_alu_seq();
    restart(1'b1);
    load(16'h0000, {8'hAB, 8'hC2, 8'h47, 8'h48, 8'hA9, 8'h3D, 8'hA4, 8'h0F, 8'hAB, 8'h02, 8'hA5, 8'hFD,
      8'hA7, 8'hFE, 8'hAF, 8'h80, 8'h9E, 8'hEB, 8'h03, 8'h17, 8'h40, 8'h07, 8'h40, 8'h02});
    load(16'h001A, {8'h01, 8'h40, 8'hFC});
    load(16'h0100, {8'h05});
    load(16'h0040, {8'hFF});
    rst_i = 1'b0;
    exec(2, 8'hC2, 8'h6C);
    exec(1, 8'hE1, 8'hEC);
    exec(1, 8'hC2, 8'h6D);
    exec(2, 8'h00, 8'h7B);
    exec(2, 8'h00, 8'h7B);
    exec(2, 8'h02, 8'h68);
    exec(2, 8'h02, 8'h6A);
    exec(2, 8'h02, 8'h6A);
    check(sp, 16'h00FD);
    exec(2, 8'h02, 8'h6A);
    check(idx, 16'hFF80);
    exec(4, 8'h07, 8'h68);
    exec(4, 8'h07, 8'h68);
    check(16'(mem.mem_q[16'h0040]), 16'h00F7);
    exec(5, 8'h07, 8'h68);
    check(addr, 16'h001A);
    exec(5, 8'h07, 8'h69);
    check(addr, 16'h001D);
    // Blank byte after the last instruction retires as an unhandled no-op
    @(posedge clk_i);
    #1;
    check(16'(illegal), 16'h0001);
    check(pc, 16'h001E);
    $display("Test alu_seq done");
  endtask
  // Every branch code with a backward offset, taken and not except 29, 2C, 2D and 91 (one outcome each)
  task automatic test_branches();
    logic [31:0] e;
    for (int k = 0; k < 24; k++)
    begin
      e = BR_TAB[k];
      restart(e[4]);
      load(16'h0000, {8'hAB, e[31:24], 8'hAB, e[23:16], e[15:8], 8'h80});
      rst_i = 1'b0;
      step(2);
      step(2);
      step(3);
      check(addr, e[0] ? 16'hFF86 : 16'h0006);
      check(16'(flags), 16'(add_flags(e[31:24], e[23:16])));
    end
    $display("Test branches done");
  endtask
  task automatic complete_run();
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    n_fail = 0;
    n_compared = 0;
    n_cycles = 0;
    rst_i = 1'b1;
    irq_n = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    test_alu_seq();
    test_branches();
    complete_run();
  end
endmodule // cids_core_bench

// [verif/cids_mem_model.sv]
// Behavioural program and data memory on the core bus
`timescale 1ns/1ns
module cids_mem_model
(
  input  wire logic        clk_i,   // Core clock
  input  wire logic [15:0] addr_i,  // Byte address
  input  wire logic        wr_i,    // Write strobe
  input  wire logic [7:0]  wdata_i, // Write data
  output logic      [7:0]  rdata_o  // Read data, same cycle
);
  // ==========================================================
  // Storage, also preloaded by the bench
  logic [7:0] mem_q [0:65535];
  // Asynchronous read: the core has no wait states
  assign rdata_o = mem_q[addr_i];
  // Write lands on the edge that ends the strobe cycle
  always @(posedge clk_i)
  begin
    if (wr_i)
    begin
      mem_q[addr_i] <= wdata_i;
    end
  end
endmodule // cids_mem_model
